/* core/frc_defs.vh */
// Constants for the flash reset and status sequencing host controller
`ifndef FRC_DEFS_VH
`define FRC_DEFS_VH

`define FRC_CLK_NS 20
// Reset pulse low time and recovery waits, in ns
`define FRC_RESET_PULSE_NS 500
`define FRC_READY_ALGO_NS 20000
`define FRC_READY_IDLE_NS 500
`define FRC_RESET_HIGH_NS 50
`define FRC_BUSY_DELAY_NS 35
`define FRC_UNPROT_SETUP_NS 4000
// Bus strobe phase lengths, in ns
`define FRC_STROBE_NS 100
`define FRC_RECOVER_NS 40
// Cycle counts: least times round up
`define FRC_CYC_UP(ns) (((ns) + `FRC_CLK_NS - 1) / `FRC_CLK_NS)
`define FRC_CNT_W 16
`define FRC_DQ_W 16
`define FRC_ADDR_W 18
`define FRC_TOGGLE_BIT 6
`define FRC_SUSP_TOGGLE_BIT 2
`define FRC_POLL_BIT 7

// Command codes on i_cmd
`define FRC_CMD_RESET 3'h0
`define FRC_CMD_READ 3'h1
`define FRC_CMD_WRITE 3'h2
`define FRC_CMD_WAIT_DONE 3'h3
`define FRC_CMD_UNPROTECT 3'h4
`define FRC_CMD_SUSP_CHECK 3'h5

`endif

/* core/frc_host.v */
// Host controller sequencing reset, strobes and status polling of a parallel flash
`timescale 1ns/1ps
`include "frc_defs.vh"

module frc_host (
    input wire i_clk,
    input wire i_rst_b,
    input wire i_cmd_valid,
    input wire [2:0] i_cmd,
    input wire i_cmd_last_write,
    input wire i_cmd_use_oe,
    input wire [`FRC_ADDR_W-1:0] i_cmd_addr,
    input wire [`FRC_DQ_W-1:0] i_cmd_data,
    input wire [`FRC_DQ_W-1:0] i_dq_in,
    input wire i_ready_busy_n,
    output reg o_cmd_ready,
    output reg o_done,
    output reg o_result_flag,
    output reg [`FRC_DQ_W-1:0] o_rdata,
    output reg o_ce_n,
    output reg o_oe_n,
    output reg o_we_n,
    output reg o_reset_n,
    output reg o_reset_unprotect,
    output reg [`FRC_ADDR_W-1:0] o_addr,
    output reg [`FRC_DQ_W-1:0] o_dq_out,
    output reg o_dq_oe
);

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
localparam integer RP_CYC_I = `FRC_CYC_UP(`FRC_RESET_PULSE_NS);
localparam integer RDY_ALGO_CYC_I = `FRC_CYC_UP(`FRC_READY_ALGO_NS);
localparam integer RDY_IDLE_CYC_I = `FRC_CYC_UP(`FRC_READY_IDLE_NS);
localparam integer RH_CYC_I = `FRC_CYC_UP(`FRC_RESET_HIGH_NS);
localparam integer BUSY_CYC_I = `FRC_CYC_UP(`FRC_BUSY_DELAY_NS);
localparam integer RSP_CYC_I = `FRC_CYC_UP(`FRC_UNPROT_SETUP_NS);
localparam integer STB_CYC_I = `FRC_CYC_UP(`FRC_STROBE_NS);
localparam integer REC_CYC_I = `FRC_CYC_UP(`FRC_RECOVER_NS);
localparam [`FRC_CNT_W-1:0] RP_CYC = RP_CYC_I[`FRC_CNT_W-1:0];
localparam [`FRC_CNT_W-1:0] RDY_ALGO_CYC = RDY_ALGO_CYC_I[`FRC_CNT_W-1:0];
localparam [`FRC_CNT_W-1:0] RDY_IDLE_CYC = RDY_IDLE_CYC_I[`FRC_CNT_W-1:0];
localparam [`FRC_CNT_W-1:0] RH_CYC = RH_CYC_I[`FRC_CNT_W-1:0];
localparam [`FRC_CNT_W-1:0] BUSY_CYC = BUSY_CYC_I[`FRC_CNT_W-1:0];
localparam [`FRC_CNT_W-1:0] RSP_CYC = RSP_CYC_I[`FRC_CNT_W-1:0];
localparam [`FRC_CNT_W-1:0] STB_CYC = STB_CYC_I[`FRC_CNT_W-1:0];
localparam [`FRC_CNT_W-1:0] REC_CYC = REC_CYC_I[`FRC_CNT_W-1:0];
localparam [`FRC_CNT_W-1:0] ONE = 16'h0001;

// ----------------------------------------------------------------
// States
// ----------------------------------------------------------------
localparam [3:0] ST_IDLE = 4'h0;
localparam [3:0] ST_RST_LOW = 4'h1;
localparam [3:0] ST_RST_WAIT = 4'h2;
localparam [3:0] ST_RST_HIGH = 4'h3;
localparam [3:0] ST_STROBE = 4'h4;
localparam [3:0] ST_RECOVER = 4'h5;
localparam [3:0] ST_BUSY_WAIT = 4'h6;
localparam [3:0] ST_POLL = 4'h7;
localparam [3:0] ST_UNPROT = 4'h8;
localparam [3:0] ST_FINISH = 4'h9;

reg [3:0] state_reg;
reg [3:0] state_next;
reg [`FRC_CNT_W-1:0] cnt_reg;
reg [`FRC_CNT_W-1:0] cnt_next;
reg [2:0] op_reg;
reg op_last_reg;
reg op_use_oe_reg;
reg busy_seen_reg;
reg have_prev_reg;
reg have_data_reg;
reg [`FRC_DQ_W-1:0] prev_reg;
reg [`FRC_DQ_W-1:0] data_reg;
reg [`FRC_DQ_W-1:0] sample;
reg bit_moved;

function toggled;
    input [`FRC_DQ_W-1:0] a;
    input [`FRC_DQ_W-1:0] b;
    input integer pos;
    begin
        toggled = a[pos] ^ b[pos];
    end
endfunction

always @* begin
    state_next = state_reg;
    cnt_next = (cnt_reg != {`FRC_CNT_W{1'b0}}) ? cnt_reg - ONE : cnt_reg;
    sample = i_dq_in;
    bit_moved = 1'b0;
    case (state_reg)
        ST_IDLE: begin
            if (i_cmd_valid && o_cmd_ready) begin
                case (i_cmd)
                    `FRC_CMD_RESET: begin
                        state_next = ST_RST_LOW;
                        cnt_next = RP_CYC;
                    end
                    `FRC_CMD_UNPROTECT: begin
                        state_next = ST_UNPROT;
                        cnt_next = RSP_CYC;
                    end
                    `FRC_CMD_READ, `FRC_CMD_WRITE, `FRC_CMD_WAIT_DONE,
                    `FRC_CMD_SUSP_CHECK: begin
                        state_next = ST_STROBE;
                        cnt_next = STB_CYC;
                    end
                    default: state_next = ST_FINISH;
                endcase
            end
        end
        ST_RST_LOW: begin
            if (cnt_reg == ONE) begin
                state_next = ST_RST_WAIT;
                // Busy at assertion means an algorithm was aborted: longer wait
                cnt_next = busy_seen_reg ? RDY_ALGO_CYC : RDY_IDLE_CYC;
            end
        end
        ST_RST_WAIT: begin
            if (cnt_reg == ONE) begin
                state_next = ST_RST_HIGH;
                cnt_next = RH_CYC;
            end
        end
        ST_RST_HIGH, ST_UNPROT: begin
            if (cnt_reg == ONE) begin
                state_next = ST_FINISH;
            end
        end
        ST_STROBE: begin
            if (cnt_reg == ONE) begin
                state_next = ST_RECOVER;
                cnt_next = REC_CYC;
            end
        end
        ST_RECOVER: begin
            if (cnt_reg == ONE) begin
                if (op_reg == `FRC_CMD_WRITE && op_last_reg) begin
                    state_next = ST_BUSY_WAIT;
                    cnt_next = BUSY_CYC;
                end else if (op_reg == `FRC_CMD_WAIT_DONE) begin
                    state_next = ST_POLL;
                end else if (op_reg == `FRC_CMD_SUSP_CHECK && !have_prev_reg) begin
                    state_next = ST_STROBE;
                    cnt_next = STB_CYC;
                end else begin
                    state_next = ST_FINISH;
                end
            end
        end
        ST_BUSY_WAIT: begin
            if (cnt_reg == ONE) begin
                state_next = ST_FINISH;
            end
        end
        ST_POLL: begin
            // Two successive status reads; stop when the toggle bit holds still and i_ready_busy_n is high
            bit_moved = toggled(prev_reg, data_reg, `FRC_TOGGLE_BIT);
            if (have_prev_reg && !bit_moved && i_ready_busy_n) begin
                state_next = ST_FINISH;
            end else begin
                state_next = ST_STROBE;
                cnt_next = STB_CYC;
            end
        end
        ST_FINISH: state_next = ST_IDLE;
        default: state_next = ST_IDLE;
    endcase
end

always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
        state_reg <= ST_IDLE;
        cnt_reg <= {`FRC_CNT_W{1'b0}};
        op_reg <= `FRC_CMD_RESET;
        op_last_reg <= 1'b0;
        op_use_oe_reg <= 1'b0;
        busy_seen_reg <= 1'b0;
        have_prev_reg <= 1'b0;
        have_data_reg <= 1'b0;
        prev_reg <= {`FRC_DQ_W{1'b0}};
        data_reg <= {`FRC_DQ_W{1'b0}};
        o_cmd_ready <= 1'b0;
        o_done <= 1'b0;
        o_result_flag <= 1'b0;
        o_rdata <= {`FRC_DQ_W{1'b0}};
        o_ce_n <= 1'b1;
        o_oe_n <= 1'b1;
        o_we_n <= 1'b1;
        o_reset_n <= 1'b1;
        o_reset_unprotect <= 1'b0;
        o_addr <= {`FRC_ADDR_W{1'b0}};
        o_dq_out <= {`FRC_DQ_W{1'b0}};
        o_dq_oe <= 1'b0;
    end else begin
        state_reg <= state_next;
        cnt_reg <= cnt_next;
        o_done <= (state_next == ST_FINISH);
        o_cmd_ready <= (state_next == ST_IDLE);
        if (state_reg == ST_IDLE && i_cmd_valid && o_cmd_ready) begin
            op_reg <= i_cmd;
            op_last_reg <= i_cmd_last_write;
            op_use_oe_reg <= i_cmd_use_oe;
            have_prev_reg <= 1'b0;
            have_data_reg <= 1'b0;
            busy_seen_reg <= ~i_ready_busy_n;
            o_result_flag <= 1'b0;
            // Toggle polling works at any address; callers give a valid one anyway
            o_addr <= i_cmd_addr;
            o_dq_out <= i_cmd_data;
        end
        // Reset pin
        o_reset_n <= ~(state_next == ST_RST_LOW);
        o_reset_unprotect <= (state_next == ST_UNPROT) ||
                             (o_reset_unprotect && state_next != ST_RST_LOW);
        // Strobes: CE stays low for OE-paced polling, else CE pulses each read
        o_we_n <= ~(state_next == ST_STROBE && op_reg == `FRC_CMD_WRITE);
        o_oe_n <= ~(state_next == ST_STROBE && op_reg != `FRC_CMD_WRITE);
        o_ce_n <= ~(state_next == ST_STROBE ||
                    (op_use_oe_reg && op_reg != `FRC_CMD_WRITE &&
                     (state_next == ST_RECOVER || state_next == ST_POLL)));
        // Data held through recovery: the flash latches it as the strobe rises
        o_dq_oe <= ((state_next == ST_STROBE || state_next == ST_RECOVER) &&
                    op_reg == `FRC_CMD_WRITE);
        // Capture read data at the end of the strobe phase
        if (state_reg == ST_STROBE && cnt_reg == ONE && op_reg != `FRC_CMD_WRITE) begin
            data_reg <= sample;
            prev_reg <= data_reg;
            have_data_reg <= 1'b1;
            // A pair exists only from the second read of the same command
            have_prev_reg <= have_data_reg && (op_reg != `FRC_CMD_READ);
            o_rdata <= sample;
        end
        if (state_reg == ST_RECOVER && cnt_reg == ONE && op_reg == `FRC_CMD_SUSP_CHECK &&
            have_prev_reg) begin
            o_result_flag <= toggled(prev_reg, data_reg, `FRC_SUSP_TOGGLE_BIT);
        end
        if (state_reg == ST_POLL && state_next == ST_FINISH) begin
            // Poll bit equals stored data once complete
            o_result_flag <= data_reg[`FRC_POLL_BIT] ^ o_dq_out[`FRC_POLL_BIT];
        end
    end
end

endmodule

/* testbench/frc_flash_model.sv */
// Behavioural parallel flash answering the host controller
`timescale 1ns/1ps
module frc_flash_model #(
    parameter ALGO_NS = 2000,
    parameter ABORT_NS = 5000,
    parameter [2:0] SUSP_SECTOR = 3'h2
) (
    input wire i_ce_n,
    input wire i_oe_n,
    input wire i_we_n,
    input wire i_reset_n,
    input wire i_suspended,
    input wire [17:0] i_addr,
    input wire [15:0] i_dq,
    output wire [15:0] o_dq,
    output wire o_ready_busy_n
);
    reg [15:0] mem [0:255];
    reg [15:0] prog_value = 16'h0000;
    reg [15:0] last = 16'h0000;
    reg [7:0] prog_loc = 8'h00;
    reg busy = 1'b0;
    reg tgl = 1'b0;
    integer k;
    wire rd_n = i_ce_n | i_oe_n | !i_reset_n;
    wire wr_n = i_ce_n | i_we_n;
    wire in_sec = i_suspended && i_addr[16:14] == SUSP_SECTOR;
    wire [15:0] st = {8'h00, ~prog_value[7], tgl, 6'h00};
    wire [15:0] dout = busy ? st : in_sec ? {13'h0000, tgl, 2'h0} : mem[i_addr[7:0]];
    // ---------------------------------------------
    // Bus and embedded algorithm
    // ---------------------------------------------
    initial for (k = 0; k < 256; k = k + 1) mem[k] = 16'hFFFF;
    // No pull-up: a released bus shows the inverse of the last value
    assign o_dq = rd_n ? ~last : dout;
    assign o_ready_busy_n = !busy;
    always @(negedge rd_n) tgl <= !tgl;
    always @(posedge rd_n) last <= dout;
    // Address bit 17 marks the final write of a sequence
    always @(posedge wr_n) begin
        if (i_reset_n && i_addr[17] && !busy) begin
            prog_loc = i_addr[7:0];
            prog_value = i_dq;
            #30 busy = 1'b1;
        end
    end
    // Shortened run time; a real sector erase is about 1 s
    always begin : algo
        @(posedge busy);
        #(ALGO_NS);
        mem[prog_loc] = prog_value;
        busy = 1'b0;
    end
    // Idle reset needs no recovery at all
    always @(negedge i_reset_n) begin
        if (busy) begin
            disable algo;
            #(ABORT_NS) busy = 1'b0;
        end
    end
endmodule

/* testbench/frc_host_sva.sv */
// Port assertions for the flash host controller
`timescale 1ns/1ps
`include "frc_defs.vh"
module frc_host_sva (
    input wire i_clk,
    input wire i_rst_b,
    input wire i_cmd_valid,
    input wire [2:0] i_cmd,
    input wire i_ready_busy_n,
    input wire o_cmd_ready,
    input wire o_done,
    input wire o_ce_n,
    input wire o_oe_n,
    input wire o_we_n,
    input wire o_reset_n,
    input wire o_reset_unprotect,
    input wire [`FRC_ADDR_W-1:0] o_addr
);
    reg [10:0] rst_cnt_reg;
    reg rst_busy_reg;
    reg [7:0] unp_cnt_reg;
    reg [2:0] cmd_reg;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_cnt_reg <= 11'h7FF;
            rst_busy_reg <= 1'b0;
            unp_cnt_reg <= 8'h00;
            cmd_reg <= 3'h0;
        end else begin
            rst_cnt_reg <= $fell(o_reset_n) ? 11'h001 : rst_cnt_reg + (rst_cnt_reg != 11'h7FF);
            rst_busy_reg <= $fell(o_reset_n) ? !i_ready_busy_n : rst_busy_reg;
            unp_cnt_reg <= !o_reset_unprotect ? 8'h00 : unp_cnt_reg + (unp_cnt_reg != 8'hFF);
            cmd_reg <= (i_cmd_valid && o_cmd_ready) ? i_cmd : cmd_reg;
        end
    end
    a_reset_recovery_wait: assert property ($fell(o_ce_n) |->
        rst_cnt_reg >= (rst_busy_reg ? 11'h3E8 : 11'h019)) else $error("access too soon");
    a_reset_high_read: assert property ($rose(o_reset_n) |-> o_oe_n [*3])
        else $error("read too soon after reset release");
    a_oe_with_ce: assert property (!o_oe_n |-> !o_ce_n && o_we_n)
        else $error("output enable without chip select");
    a_poll_addr_stable: assert property (!o_oe_n && !$past(o_oe_n) |-> $stable(o_addr))
        else $error("address moved during read");
    a_unprot_setup: assert property ($fell(o_we_n) |->
        !o_reset_unprotect || unp_cnt_reg >= 8'hC8) else $error("write too soon");
    a_done_when_ready: assert property (o_done && cmd_reg == `FRC_CMD_WAIT_DONE |->
        i_ready_busy_n) else $error("done while flash busy");
endmodule
bind frc_host frc_host_sva chk_u (.i_clk, .i_rst_b, .i_cmd_valid, .i_cmd, .i_ready_busy_n,
    .o_cmd_ready, .o_done, .o_ce_n, .o_oe_n, .o_we_n, .o_reset_n, .o_reset_unprotect, .o_addr);

/* testbench/test_frc_host.sv */
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
`include "frc_defs.vh"
module test_frc_host;
    reg clk = 0, rst_b = 0, cv = 0, lw = 0, uo = 0, susp = 0;
    reg [2:0] cmd = 3'h0;
    reg [17:0] ca = 18'h00000;
    reg [15:0] cd = 16'h0000, prog_value;
    reg [17:0] nt;
    reg [17:0] q[$];
    reg [31:0] r;
    reg [7:0] prog_loc;
    integer bad_count = 0, checked = 0, seed = 32'h1D8F;
    wire o_cmd_ready, o_done, o_result_flag, o_ce_n, o_oe_n, o_we_n, o_reset_n, o_unp, o_dq_oe;
    wire f_rb;
    wire [15:0] o_rdata, o_dq_out, f_dq;
    wire [17:0] o_addr;
    wire [15:0] dq = o_dq_oe ? o_dq_out : f_dq;
    always #10 clk = ~clk;
    frc_host dut_u (.i_clk(clk), .i_rst_b(rst_b), .i_cmd_valid(cv), .i_cmd(cmd),
        .i_cmd_last_write(lw), .i_cmd_use_oe(uo), .i_cmd_addr(ca), .i_cmd_data(cd),
        .i_dq_in(dq), .i_ready_busy_n(f_rb), .o_cmd_ready(o_cmd_ready), .o_done(o_done),
        .o_result_flag(o_result_flag), .o_rdata(o_rdata), .o_ce_n(o_ce_n), .o_oe_n(o_oe_n),
        .o_we_n(o_we_n), .o_reset_n(o_reset_n), .o_reset_unprotect(o_unp), .o_addr(o_addr),
        .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe));
    frc_flash_model fm_u (.i_ce_n(o_ce_n), .i_oe_n(o_oe_n), .i_we_n(o_we_n),
        .i_reset_n(o_reset_n), .i_suspended(susp), .i_addr(o_addr), .i_dq(dq),
        .o_dq(f_dq), .o_ready_busy_n(f_rb));
    // ---------------------------------------------
    // Driver, monitor and verdict
    // ---------------------------------------------
    task check(input [15:0] seen, input [15:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    // Note kind: 0 none, 1 read data, 2 result flag
    task run(input [2:0] c, input [17:0] a, input [15:0] d, input l, input [17:0] n_in);
        integer n;
        begin
            q.push_back(n_in);
            n = 0;
            while (o_cmd_ready !== 1'b1 && n < 3000) @(negedge clk) n = n + 1;
            cmd = c;
            ca = a;
            cd = d;
            lw = l;
            r = $random(seed);
            uo = r[0];
            cv = 1;
            @(negedge clk);
            cv = 0;
            while (o_done !== 1'b1 && n < 3000) @(negedge clk) n = n + 1;
            if (n >= 3000) bad_count = bad_count + 1;
            @(negedge clk);
        end
    endtask
    always @(negedge clk) begin
        if (o_done === 1'b1 && q.size() > 0) begin
            nt = q.pop_front();
            if (nt[17:16] == 2'd1) check(o_rdata, nt[15:0]);
            if (nt[17:16] == 2'd2) check({15'h0000, o_result_flag}, nt[15:0]);
        end
    end
    task give_verdict;
        begin
            $display("comparisons %0d, mismatches %0d", checked, bad_count);
            if (bad_count == 0 && checked > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    // Longest run, the reset abort, is about a thousand cycles
    initial begin
        #400000;
        bad_count = bad_count + 1;
        give_verdict;
    end
    initial begin
        repeat (2) @(negedge clk);
        rst_b = 1;
        r = $random(seed);
        prog_loc = r[7:0];
        prog_value = r[23:8];
        run(`FRC_CMD_RESET, 18'h00000, 16'h0000, 0, 18'h00000);
        run(`FRC_CMD_READ, {10'h000, prog_loc}, 16'h0000, 0, {2'd1, 16'hFFFF});
        $display("test idle reset and erased read done");
        run(`FRC_CMD_WRITE, 18'h00000, 16'h00AA, 0, 18'h00000);
        run(`FRC_CMD_WRITE, {10'h200, prog_loc}, prog_value, 1, 18'h00000);
        run(`FRC_CMD_WAIT_DONE, {10'h000, prog_loc}, prog_value, 0, {2'd2, 16'h0000});
        run(`FRC_CMD_READ, {10'h000, prog_loc}, 16'h0000, 0, {2'd1, prog_value});
        run(`FRC_CMD_READ, {10'h000, prog_loc}, 16'h0000, 0, {2'd1, prog_value});
        $display("test program and readback done");
        run(`FRC_CMD_WRITE, {10'h200, prog_loc + 8'h01}, ~prog_value, 1, 18'h00000);
        run(`FRC_CMD_RESET, 18'h00000, 16'h0000, 0, 18'h00000);
        run(`FRC_CMD_READ, {10'h000, prog_loc + 8'h01}, 16'h0000, 0, {2'd1, 16'hFFFF});
        $display("test reset abort done");
        susp = 1;
        run(`FRC_CMD_SUSP_CHECK, 18'h08003, 16'h0000, 0, {2'd2, 16'h0001});
        run(`FRC_CMD_SUSP_CHECK, 18'h00010, 16'h0000, 0, {2'd2, 16'h0000});
        susp = 0;
        $display("test suspend toggle done");
        run(`FRC_CMD_UNPROTECT, 18'h00000, 16'h0000, 0, 18'h00000);
        check({15'h0000, o_unp}, 16'h0001);
        run(`FRC_CMD_WRITE, 18'h00005, 16'h0000, 0, 18'h00000);
        check({15'h0000, o_unp}, 16'h0001);
        run(`FRC_CMD_RESET, 18'h00000, 16'h0000, 0, 18'h00000);
        check({15'h0000, o_unp}, 16'h0000);
        $display("test unprotect done");
        give_verdict;
    end
endmodule
